// [common/scs_pkg.sv]
// Constants for the serial control and clock select block.
// Assumes a 32-bit AXI4-Lite master and one 125 MHz clock.
package scs_pkg;

  // ************************************************************
  // Register byte addresses
  // ************************************************************
  localparam logic [4:0] SCS_OFF_CTRL = 5'h00;
  localparam logic [4:0] SCS_OFF_MODE = 5'h04;
  localparam logic [4:0] SCS_OFF_CARD = 5'h08;
  localparam logic [4:0] SCS_OFF_STAT = 5'h0c;
  localparam logic [4:0] SCS_OFF_TXD = 5'h10;
  localparam logic [4:0] SCS_OFF_RXD = 5'h14;

  // ************************************************************
  // serial_control_reg fields
  // ************************************************************
  localparam int SCS_CTRL_TX_IRQ_EN = 7;
  localparam int SCS_CTRL_RX_IRQ_EN = 6;
  localparam int SCS_CTRL_TX_EN = 5;
  localparam int SCS_CTRL_RX_EN = 4;
  localparam int SCS_CTRL_WAKE_EN = 3;
  localparam int SCS_CTRL_TX_END_IRQ_EN = 2;
  localparam int SCS_CTRL_CKH = 1;
  localparam int SCS_CTRL_CKL = 0;
  localparam logic [7:0] SCS_CTRL_RST = 8'h00;

  // ************************************************************
  // serial_mode_reg and card_mode_reg fields
  // ************************************************************
  localparam int SCS_MODE_SYNC = 0;
  localparam int SCS_MODE_MULTIPROC = 1;
  localparam int SCS_MODE_GUARD = 2;
  localparam logic [2:0] SCS_MODE_RST = 3'h0;
  localparam int SCS_CARD_SEL = 0;
  localparam logic SCS_CARD_RST = 1'b0;

  // ************************************************************
  // Status fields
  // ************************************************************
  localparam int SCS_ST_TXROOM = 0;
  localparam int SCS_ST_RXFULL = 1;
  localparam int SCS_ST_FRAME = 2;
  localparam int SCS_ST_OVRUN = 3;
  localparam int SCS_ST_TXEND = 4;
  localparam int SCS_ST_TXEMPTY = 5;
  localparam int SCS_ST_MPB = 6;

  // ************************************************************
  // Buffer and bus codes
  // ************************************************************
  localparam int SCS_FIFO_DEPTH = 32;
  localparam int SCS_FIFO_WIDTH = 8;
  localparam logic [1:0] SCS_RESP_OKAY = 2'h0;
  localparam logic [1:0] SCS_RESP_SLVERR = 2'h2;

endpackage

// [core/scs_ctrl.sv]
// Serial control register, clock source select and transmit buffer.
// Assumes an AXI4-Lite master, a bit-rate clock level from the baud
// generator, and a shifter core that takes and gives characters.
//
// Operation
// - Async 00: internal clock, pin is port
// - Async 01: internal clock, bit clock out
// - Async 1x: external x16 clock from pin
// - Sync 0x: internal clock driven out
// - Sync 1x: pin is clock input
// - Card mode select picks card meanings
// - Card mode: tx irq needs bit 7
// - Rx data and error irq need bit 6
// - Transmit only while bit 5 set
// - Receive only while bit 4 set
// - Wake enable only async with multiproc format
// - Card, no guard: 00 port, 01 clock
// - Card guard: 00 low, 10 high, x1 clock
// - Guard mode clock setting switches live
// - Wake enable skips mpb 0, clears on 1
`timescale 1ns/100ps

// ************************************************************
// Synchronous FIFO
// ************************************************************
module scs_fifo #(
  parameter int WIDTH = 8,
  parameter int DEPTH = 32
) (
  input wire logic core_clk_in,
  input wire logic rst_in,
  input wire logic in_valid_in,
  output logic in_ready_out,
  input wire logic [WIDTH-1:0] in_data_in,
  output logic out_valid_out,
  input wire logic out_ready_in,
  output logic [WIDTH-1:0] out_data_out
);
  localparam int AW = $clog2(DEPTH);
  logic [WIDTH-1:0] mem_q [DEPTH];
  logic [AW-1:0] wr_ptr_q;
  logic [AW-1:0] rd_ptr_q;
  logic [AW:0] count_q;
  wire push = in_valid_in && in_ready_out;
  wire pop = out_valid_out && out_ready_in;

  assign in_ready_out = (count_q != (AW+1)'(DEPTH));
  assign out_valid_out = (count_q != '0);
  assign out_data_out = mem_q[rd_ptr_q];

  always_ff @(posedge core_clk_in) begin
    if (rst_in) begin
      wr_ptr_q <= '0;
      rd_ptr_q <= '0;
      count_q <= '0;
    end else begin
      if (push) begin
        mem_q[wr_ptr_q] <= in_data_in;
        wr_ptr_q <= wr_ptr_q + 1'b1;
      end
      if (pop) begin
        rd_ptr_q <= rd_ptr_q + 1'b1;
      end
      if (push && !pop) begin
        count_q <= count_q + 1'b1;
      end else if (pop && !push) begin
        count_q <= count_q - 1'b1;
      end
    end
  end
endmodule // scs_fifo

// ************************************************************
// Top level
// ************************************************************
module scs_ctrl
  import scs_pkg::*;
(
  input wire logic core_clk_in,
  input wire logic rst_in,
  input wire logic s_axi_awvalid,
  output logic s_axi_awready,
  input wire logic [4:0] s_axi_awaddr,
  input wire logic s_axi_wvalid,
  output logic s_axi_wready,
  input wire logic [31:0] s_axi_wdata,
  input wire logic [3:0] s_axi_wstrb,
  output logic s_axi_bvalid,
  input wire logic s_axi_bready,
  output logic [1:0] s_axi_bresp,
  input wire logic s_axi_arvalid,
  output logic s_axi_arready,
  input wire logic [4:0] s_axi_araddr,
  output logic s_axi_rvalid,
  input wire logic s_axi_rready,
  output logic [31:0] s_axi_rdata,
  output logic [1:0] s_axi_rresp,
  input wire logic brg_clk_in,
  input wire logic sck_in,
  output logic sck_out,
  output logic sck_oe_n_out,
  output logic sck_is_port_out,
  output logic xfer_clk_out,
  output logic xfer_clk_ext_out,
  output logic ext_clk_x16_out,
  output logic tx_enable_out,
  output logic tx_valid_out,
  input wire logic tx_ready_in,
  output logic [7:0] tx_data_out,
  input wire logic tx_end_in,
  output logic rx_enable_out,
  input wire logic rx_valid_in,
  input wire logic [7:0] rx_data_in,
  input wire logic rx_mpb_in,
  input wire logic rx_frame_err_in,
  output logic tx_data_irq_out,
  output logic rx_data_irq_out,
  output logic rx_error_irq_out,
  output logic tx_end_irq_out
);

  // ************************************************************
  // State
  // ************************************************************
  logic [7:0] serial_control_reg_q, rx_data_q;
  logic [2:0] serial_mode_reg_q;
  logic [4:0] aw_addr_q;
  logic [31:0] w_data_q, rdata_d, rdata_q;
  logic [1:0] bresp_q, rresp_q;
  logic card_mode_reg_q, aw_full_q, w_full_q, w_lane_q, bvalid_q, rvalid_q;
  logic rx_mpb_q, rx_full_q, rx_frame_q, rx_ovrun_q;
  logic sck_q, sck_oe_n_q, sck_port_q, xfer_clk_q, xfer_ext_q, x16_q;

  // ************************************************************
  // Control decode
  // ************************************************************
  wire [1:0] clk_sel = {serial_control_reg_q[SCS_CTRL_CKH],
                        serial_control_reg_q[SCS_CTRL_CKL]};
  wire tx_irq_enable = serial_control_reg_q[SCS_CTRL_TX_IRQ_EN];
  wire rx_irq_enable = serial_control_reg_q[SCS_CTRL_RX_IRQ_EN];
  wire tx_enable = serial_control_reg_q[SCS_CTRL_TX_EN];
  wire rx_enable = serial_control_reg_q[SCS_CTRL_RX_EN];
  wire addr_wake_enable = serial_control_reg_q[SCS_CTRL_WAKE_EN];
  wire tx_end_irq_enable = serial_control_reg_q[SCS_CTRL_TX_END_IRQ_EN];
  wire sync_mode = serial_mode_reg_q[SCS_MODE_SYNC];
  wire multiproc_format = serial_mode_reg_q[SCS_MODE_MULTIPROC];
  wire block_guard_mode = serial_mode_reg_q[SCS_MODE_GUARD];
  wire card_mode_select = card_mode_reg_q;
  // Card mode takes no wake feature; bit 3 is masked while card mode is selected
  wire wake_active = addr_wake_enable && multiproc_format
                     && !sync_mode && !card_mode_select;

  // ************************************************************
  // Clock pin function
  // ************************************************************
  // Rebuilt every cycle, so guard mode switches without a stop
  wire card_guard = card_mode_select && block_guard_mode;
  wire card_plain = card_mode_select && !block_guard_mode;
  wire sel_drive_clk =
      (card_guard && clk_sel[0])
    || (card_plain && clk_sel == 2'h1)
    || (!card_mode_select && sync_mode && !clk_sel[1])
    || (!card_mode_select && !sync_mode
        && clk_sel == 2'h1);
  wire sel_drive_low = card_guard && clk_sel == 2'h0;
  wire sel_drive_high = card_guard && clk_sel == 2'h2;
  wire sel_ext = !card_mode_select && clk_sel[1];
  // Reserved card codes 1x without guard fall back to port use
  wire sel_port = !sel_drive_clk && !sel_drive_low
                  && !sel_drive_high && !sel_ext;
  always_ff @(posedge core_clk_in) begin
    if (rst_in) begin
      sck_q <= 1'b0;
      sck_oe_n_q <= 1'b1;
      sck_port_q <= 1'b1;
      xfer_clk_q <= 1'b0;
      xfer_ext_q <= 1'b0;
      x16_q <= 1'b0;
    end else begin
      sck_q <= sel_drive_clk ? brg_clk_in : sel_drive_high;
      sck_oe_n_q <= !(sel_drive_clk || sel_drive_low
                      || sel_drive_high);
      sck_port_q <= sel_port;
      xfer_clk_q <= sel_ext ? sck_in : brg_clk_in;
      xfer_ext_q <= sel_ext;
      x16_q <= sel_ext && !sync_mode;
    end
  end
  assign sck_out = sck_q;
  assign sck_oe_n_out = sck_oe_n_q;
  assign sck_is_port_out = sck_port_q;
  assign xfer_clk_out = xfer_clk_q;
  assign xfer_clk_ext_out = xfer_ext_q;
  assign ext_clk_x16_out = x16_q;

  // ************************************************************
  // Write channel
  // ************************************************************
  wire fifo_in_ready;
  wire aw_take = s_axi_awvalid && !aw_full_q;
  wire w_take = s_axi_wvalid && !w_full_q;
  wire wr_ctrl = aw_addr_q == SCS_OFF_CTRL;
  wire wr_mode = aw_addr_q == SCS_OFF_MODE;
  wire wr_card = aw_addr_q == SCS_OFF_CARD;
  wire wr_stat = aw_addr_q == SCS_OFF_STAT;
  wire wr_txd = aw_addr_q == SCS_OFF_TXD;
  // Word-aligned map, so every address up to the last is mapped
  wire wr_known = aw_addr_q <= SCS_OFF_RXD;
  // A data write waits while the buffer is full: back-pressure
  wire wr_fire = aw_full_q && w_full_q && !bvalid_q
                 && (!wr_txd || fifo_in_ready || !w_lane_q);
  wire lane0 = wr_fire && w_lane_q;
  assign s_axi_awready = !aw_full_q;
  assign s_axi_wready = !w_full_q;

  always_ff @(posedge core_clk_in) begin
    if (rst_in) begin
      aw_full_q <= 1'b0;
      aw_addr_q <= 5'h00;
    end else if (aw_take) begin
      aw_full_q <= 1'b1;
      aw_addr_q <= {s_axi_awaddr[4:2], 2'h0};
    end else if (wr_fire) begin
      aw_full_q <= 1'b0;
    end
  end
  always_ff @(posedge core_clk_in) begin
    if (rst_in) begin
      w_full_q <= 1'b0;
      w_data_q <= 32'h0000_0000;
      w_lane_q <= 1'b0;
    end else if (w_take) begin
      w_full_q <= 1'b1;
      w_data_q <= s_axi_wdata;
      w_lane_q <= s_axi_wstrb[0];
    end else if (wr_fire) begin
      w_full_q <= 1'b0;
    end
  end
  always_ff @(posedge core_clk_in) begin
    if (rst_in) begin
      bvalid_q <= 1'b0;
      bresp_q <= SCS_RESP_OKAY;
    end else if (wr_fire) begin
      bvalid_q <= 1'b1;
      bresp_q <= wr_known ? SCS_RESP_OKAY : SCS_RESP_SLVERR;
    end else if (s_axi_bready) begin
      bvalid_q <= 1'b0;
    end
  end
  assign s_axi_bvalid = bvalid_q;
  assign s_axi_bresp = bresp_q;

  // ************************************************************
  // Receive capture
  // ************************************************************
  wire rd_rxd;
  wire rx_accept = rx_valid_in && rx_enable;
  wire rx_skip = wake_active && !rx_mpb_in;
  wire rx_take = rx_accept && !rx_skip;
  wire wake_clear = rx_accept && wake_active && rx_mpb_in;
  wire [1:0] stat_clr = lane0 && wr_stat ?
      {w_data_q[SCS_ST_OVRUN], w_data_q[SCS_ST_FRAME]} : 2'h0;

  always_ff @(posedge core_clk_in) begin
    if (rst_in) begin
      rx_data_q <= 8'h00;
      rx_mpb_q <= 1'b0;
    end else if (rx_take) begin
      rx_data_q <= rx_data_in;
      rx_mpb_q <= rx_mpb_in;
    end
  end
  // Setting beats a clear in the same cycle
  always_ff @(posedge core_clk_in) begin
    if (rst_in) begin
      rx_full_q <= 1'b0;
      rx_frame_q <= 1'b0;
      rx_ovrun_q <= 1'b0;
    end else begin
      rx_full_q <= rx_take || (rx_full_q && !rd_rxd);
      rx_frame_q <= (rx_take && rx_frame_err_in)
                    || (rx_frame_q && !stat_clr[0]);
      rx_ovrun_q <= (rx_take && rx_full_q && !rd_rxd)
                    || (rx_ovrun_q && !stat_clr[1]);
    end
  end

  // ************************************************************
  // Control registers
  // ************************************************************
  // A software write beats the hardware wake clear
  always_ff @(posedge core_clk_in) begin
    if (rst_in) begin
      serial_control_reg_q <= SCS_CTRL_RST;
      serial_mode_reg_q <= SCS_MODE_RST;
      card_mode_reg_q <= SCS_CARD_RST;
    end else begin
      if (lane0 && wr_ctrl) begin
        serial_control_reg_q <= w_data_q[7:0];
      end else if (wake_clear) begin
        serial_control_reg_q[SCS_CTRL_WAKE_EN] <= 1'b0;
      end
      if (lane0 && wr_mode) begin
        serial_mode_reg_q <= w_data_q[2:0];
      end
      if (lane0 && wr_card) begin
        card_mode_reg_q <= w_data_q[SCS_CARD_SEL];
      end
    end
  end

  // ************************************************************
  // Transmit buffer
  // ************************************************************
  wire fifo_out_valid;
  wire [7:0] fifo_out_data;
  wire fifo_out_ready = tx_ready_in && tx_enable;
  scs_fifo #(
    .WIDTH(SCS_FIFO_WIDTH),
    .DEPTH(SCS_FIFO_DEPTH)
  ) u_tx_fifo (
    .core_clk_in(core_clk_in),
    .rst_in(rst_in),
    .in_valid_in(lane0 && wr_txd),
    .in_ready_out(fifo_in_ready),
    .in_data_in(w_data_q[7:0]),
    .out_valid_out(fifo_out_valid),
    .out_ready_in(fifo_out_ready),
    .out_data_out(fifo_out_data)
  );
  assign tx_enable_out = tx_enable;
  assign rx_enable_out = rx_enable;
  assign tx_valid_out = fifo_out_valid && tx_enable;
  assign tx_data_out = fifo_out_data;

  // ************************************************************
  // Interrupt requests
  // ************************************************************
  // Plain gates: each request drops as soon as either input does
  assign tx_data_irq_out = tx_irq_enable && fifo_in_ready;
  assign rx_data_irq_out = rx_irq_enable && rx_full_q;
  assign rx_error_irq_out = rx_irq_enable
                            && (rx_frame_q || rx_ovrun_q);
  assign tx_end_irq_out = tx_end_irq_enable && tx_end_in;

  // ************************************************************
  // Read channel
  // ************************************************************
  wire ar_take = s_axi_arvalid && !rvalid_q;
  wire [4:0] ar_addr = {s_axi_araddr[4:2], 2'h0};
  wire rd_known = ar_addr <= SCS_OFF_RXD;
  assign s_axi_arready = !rvalid_q;
  assign rd_rxd = ar_take && ar_addr == SCS_OFF_RXD;
  always_comb begin
    rdata_d = 32'h0000_0000;
    unique case (ar_addr)
      SCS_OFF_CTRL: rdata_d[7:0] = serial_control_reg_q;
      SCS_OFF_MODE: rdata_d[2:0] = serial_mode_reg_q;
      SCS_OFF_CARD: rdata_d[SCS_CARD_SEL] = card_mode_reg_q;
      SCS_OFF_STAT: begin
        rdata_d[SCS_ST_TXROOM] = fifo_in_ready;
        rdata_d[SCS_ST_RXFULL] = rx_full_q;
        rdata_d[SCS_ST_FRAME] = rx_frame_q;
        rdata_d[SCS_ST_OVRUN] = rx_ovrun_q;
        rdata_d[SCS_ST_TXEND] = tx_end_in;
        rdata_d[SCS_ST_TXEMPTY] = !fifo_out_valid;
        rdata_d[SCS_ST_MPB] = rx_mpb_q;
      end
      SCS_OFF_RXD: rdata_d[7:0] = rx_data_q;
      default: rdata_d = 32'h0000_0000;
    endcase
  end
  always_ff @(posedge core_clk_in) begin
    if (rst_in) begin
      rvalid_q <= 1'b0;
      rdata_q <= 32'h0000_0000;
      rresp_q <= SCS_RESP_OKAY;
    end else if (ar_take) begin
      rvalid_q <= 1'b1;
      rdata_q <= rdata_d;
      rresp_q <= rd_known ? SCS_RESP_OKAY : SCS_RESP_SLVERR;
    end else if (s_axi_rready) begin
      rvalid_q <= 1'b0;
    end
  end
  assign s_axi_rvalid = rvalid_q;
  assign s_axi_rdata = rdata_q;
  assign s_axi_rresp = rresp_q;

endmodule // scs_ctrl

// [testbench/scs_checker.sv]
// Port checker for scs_ctrl, bound to its top ports.
// Assumes full-word strobes and one register write at a time.
`timescale 1ns/100ps
module scs_checker
  import scs_pkg::*;
(
  input wire logic core_clk_in,
  input wire logic rst_in,
  input wire logic s_axi_awvalid,
  input wire logic s_axi_awready,
  input wire logic [4:0] s_axi_awaddr,
  input wire logic s_axi_wvalid,
  input wire logic s_axi_wready,
  input wire logic [31:0] s_axi_wdata,
  input wire logic s_axi_bvalid,
  input wire logic [1:0] s_axi_bresp,
  input wire logic brg_clk_in,
  input wire logic sck_in,
  input wire logic sck_out,
  input wire logic sck_oe_n_out,
  input wire logic sck_is_port_out,
  input wire logic xfer_clk_out,
  input wire logic xfer_clk_ext_out,
  input wire logic ext_clk_x16_out,
  input wire logic tx_enable_out,
  input wire logic tx_valid_out,
  input wire logic rx_enable_out,
  input wire logic tx_data_irq_out,
  input wire logic rx_data_irq_out,
  input wire logic rx_error_irq_out
);
  // ****
  // Shadow registers
  // ****
  // Shadow lands one edge late, so checks skip cycles with bvalid high
  logic [4:0] aw_q;
  logic [7:0] wd_q;
  logic bv_q;
  logic [7:0] sh_q [0:2];
  always_ff @(posedge core_clk_in) begin
    bv_q <= s_axi_bvalid;
    if (s_axi_awvalid && s_axi_awready) aw_q <= s_axi_awaddr;
    if (s_axi_wvalid && s_axi_wready) wd_q <= s_axi_wdata[7:0];
    if (rst_in) sh_q <= '{default: 8'h00};
    else if (s_axi_bvalid && !bv_q && s_axi_bresp == SCS_RESP_OKAY
        && aw_q[4:2] < 3'h3) sh_q[aw_q[4:2]] <= wd_q;
  end
  wire [7:0] ct = sh_q[0];
  wire cd = sh_q[2][0];
  wire guard = sh_q[1][2];
  wire sy = sh_q[1][0];
  wire [1:0] ck = ct[1:0];
  wire qt = !s_axi_bvalid;
  wire drv = cd ? (guard || ck == 2'h1) : (sy ? !ck[1] : ck == 2'h1);
  wire ext = !cd && ck[1];
  wire prt = !drv && !ext;
  wire sel = ext ? sck_in : brg_clk_in;

  // ****
  // Assertions
  // ****
  default clocking cb @(posedge core_clk_in);
  endclocking
  default disable iff (rst_in);

  tx_gate_a: assert property (qt |-> tx_enable_out == ct[5])
    else $error("Transmit enable wrong");
  tx_hold_a: assert property (tx_valid_out |-> tx_enable_out)
    else $error("Byte offered while transmit off");
  rx_gate_a: assert property (qt |-> rx_enable_out == ct[4])
    else $error("Receive enable wrong");
  rx_irq_a: assert property (
    qt && (rx_data_irq_out || rx_error_irq_out) |-> ct[6])
    else $error("Receive irq without enable");
  tx_irq_a: assert property (qt && tx_data_irq_out |-> ct[7])
    else $error("Transmit irq without enable");
  pin_drive_a: assert property (qt [*2] |-> sck_oe_n_out == !drv)
    else $error("Clock pin drive wrong");
  pin_port_a: assert property (qt |-> sck_is_port_out == prt)
    else $error("Clock pin port flag wrong");
  pin_level_a: assert property (
    qt && cd && guard && !ck[0] |-> !sck_oe_n_out && sck_out == ck[1])
    else $error("Fixed clock level wrong");
  ext_sel_a: assert property (
    qt |-> xfer_clk_ext_out == ext && ext_clk_x16_out == (ext && !sy))
    else $error("External clock select wrong");
  xfer_clk_a: assert property (
    qt && $past(qt) && !$past(rst_in) |-> xfer_clk_out == $past(sel))
    else $error("Transfer clock source wrong");
endmodule // scs_checker

bind scs_ctrl scs_checker chk (
  .core_clk_in(core_clk_in), .rst_in(rst_in),
  .s_axi_awvalid(s_axi_awvalid), .s_axi_awready(s_axi_awready),
  .s_axi_awaddr(s_axi_awaddr), .s_axi_wvalid(s_axi_wvalid),
  .s_axi_wready(s_axi_wready), .s_axi_wdata(s_axi_wdata),
  .s_axi_bvalid(s_axi_bvalid), .s_axi_bresp(s_axi_bresp),
  .brg_clk_in(brg_clk_in), .sck_in(sck_in), .sck_out(sck_out),
  .sck_oe_n_out(sck_oe_n_out), .sck_is_port_out(sck_is_port_out),
  .xfer_clk_out(xfer_clk_out), .xfer_clk_ext_out(xfer_clk_ext_out),
  .ext_clk_x16_out(ext_clk_x16_out), .tx_enable_out(tx_enable_out),
  .tx_valid_out(tx_valid_out), .rx_enable_out(rx_enable_out),
  .tx_data_irq_out(tx_data_irq_out), .rx_data_irq_out(rx_data_irq_out),
  .rx_error_irq_out(rx_error_irq_out)
);

// [testbench/scs_peer_model.sv]
// Far side of scs_ctrl: shifter, bit clock and external pin clock.
// Assumes the bench clock; the bench reads the log of sent bytes.
`timescale 1ns/100ps
module scs_peer_model (
  input wire logic core_clk_in,
  input wire logic stall_in,
  input wire logic tx_valid_in,
  input wire logic [7:0] tx_data_in,
  output logic tx_ready_out,
  output logic tx_end_out,
  output logic rx_valid_out,
  output logic [7:0] rx_data_out,
  output logic rx_mpb_out,
  output logic rx_frame_err_out,
  output logic brg_clk_out,
  output logic sck_ext_out
);
  logic [4:0] cnt_q = 5'h00;
  logic [7:0] log_q [$];
  initial begin
    tx_end_out = 1'b1;
    rx_valid_out = 1'b0;
    rx_data_out = 8'h00;
    rx_mpb_out = 1'b0;
    rx_frame_err_out = 1'b0;
  end
  // Ready only every other cycle, so the buffer sees slow takers
  assign tx_ready_out = !stall_in && cnt_q[0];
  assign brg_clk_out = cnt_q[4];
  assign sck_ext_out = cnt_q[0]; // Sixteen times the bit clock
  always @(posedge core_clk_in) begin
    cnt_q <= cnt_q + 5'h01;
    tx_end_out <= !tx_valid_in;
    if (tx_valid_in && tx_ready_out) log_q.push_back(tx_data_in);
  end
  task automatic send(input logic [7:0] d, input logic m, input logic f);
    @(posedge core_clk_in);
    rx_valid_out <= 1'b1;
    rx_data_out <= d;
    rx_mpb_out <= m;
    rx_frame_err_out <= f;
    @(posedge core_clk_in);
    rx_valid_out <= 1'b0;
    rx_data_out <= ~d; // Released lines carry junk
    rx_mpb_out <= !m;
    rx_frame_err_out <= !f;
  endtask
endmodule // scs_peer_model

// [testbench/serial_control_clock_select_tb.sv]
// Self-checking bench for scs_ctrl over AXI4-Lite.
// Assumes the peer model on the shifter side and a pulled-up clock pin.
`timescale 1ns/100ps
module serial_control_clock_select_tb
  import scs_pkg::*;
;
  logic clk = 1'b0;
  logic rst = 1'b1;
  logic awv = 1'b0, wv = 1'b0, bry = 1'b0, arv = 1'b0, rry = 1'b0;
  logic [4:0] awa = 5'h00, ara = 5'h00;
  logic [31:0] wd = 32'h0, rd, rdat, v, seed = 32'h0000e4fc;
  logic [1:0] br, rr, resp;
  logic awr, wr, bv, arr, rv, sck_o, oe_n, port, xext, x16, brg, sck_ext;
  logic txe, txv, txr, txend, rxe, rxv, mpb, fer, tirq, rirq, eirq, teirq;
  logic ext_on = 1'b0, stall = 1'b1;
  logic [7:0] txd, rxd;
  logic [7:0] exp_q [$];
  int fail_count = 0, comparisons = 0, cyc = 0;
  wire sck_w = !oe_n ? sck_o : (ext_on ? sck_ext : 1'b1);

  always #4 clk = !clk;
  scs_ctrl uut (
    .core_clk_in(clk), .rst_in(rst),
    .s_axi_awvalid(awv), .s_axi_awready(awr), .s_axi_awaddr(awa),
    .s_axi_wvalid(wv), .s_axi_wready(wr), .s_axi_wdata(wd),
    .s_axi_wstrb(4'hf), .s_axi_bvalid(bv), .s_axi_bready(bry),
    .s_axi_bresp(br), .s_axi_arvalid(arv), .s_axi_arready(arr),
    .s_axi_araddr(ara), .s_axi_rvalid(rv), .s_axi_rready(rry),
    .s_axi_rdata(rd), .s_axi_rresp(rr), .brg_clk_in(brg),
    .sck_in(sck_w), .sck_out(sck_o), .sck_oe_n_out(oe_n),
    .sck_is_port_out(port), .xfer_clk_out(), .xfer_clk_ext_out(xext),
    .ext_clk_x16_out(x16), .tx_enable_out(txe), .tx_valid_out(txv),
    .tx_ready_in(txr), .tx_data_out(txd), .tx_end_in(txend),
    .rx_enable_out(rxe), .rx_valid_in(rxv), .rx_data_in(rxd),
    .rx_mpb_in(mpb), .rx_frame_err_in(fer), .tx_data_irq_out(tirq),
    .rx_data_irq_out(rirq), .rx_error_irq_out(eirq), .tx_end_irq_out(teirq)
  );
  scs_peer_model peer (
    .core_clk_in(clk), .stall_in(stall), .tx_valid_in(txv),
    .tx_data_in(txd), .tx_ready_out(txr), .tx_end_out(txend),
    .rx_valid_out(rxv), .rx_data_out(rxd), .rx_mpb_out(mpb),
    .rx_frame_err_out(fer), .brg_clk_out(brg), .sck_ext_out(sck_ext)
  );

  // ****
  // Helpers
  // ****
  function automatic logic [31:0] rnd();
    seed ^= seed << 13;
    seed ^= seed >> 17;
    seed ^= seed << 5;
    return seed;
  endfunction
  // Expected {oe_n, port, external, x16} of the clock pin
  function automatic logic [3:0] pins(input logic c, g, s,
                                      input logic [1:0] k);
    logic dr, ex;
    dr = c ? (g || k == 2'h1) : (s ? !k[1] : k == 2'h1);
    ex = !c && k[1];
    return {!dr, !dr && !ex, ex, ex && !s};
  endfunction
  task automatic check(input logic [31:0] seen, input logic [31:0] exp);
    comparisons++;
    if (seen !== exp) begin
      fail_count++;
      $display("MISMATCH t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask
  // One write (w high) or read; waits for the answer
  task automatic bus(input logic w, input logic [4:0] a,
                     input logic [31:0] d);
    logic pa, pw, ta, tw, hit;
    pa = 1'b1;
    pw = w;
    hit = 1'b0;
    @(posedge clk);
    awa <= a;
    ara <= a;
    wd <= d;
    awv <= w;
    wv <= w;
    arv <= !w;
    bry <= w;
    rry <= !w;
    while (!hit) begin
      @(negedge clk);
      ta = pa && (w ? awr : arr);
      tw = pw && wr;
      hit = w ? bv : rv;
      resp = w ? br : rr;
      rdat = rd;
      @(posedge clk);
      if (ta) awv <= 1'b0;
      if (ta) arv <= 1'b0;
      if (tw) wv <= 1'b0;
      pa = pa && !ta;
      pw = pw && !tw;
    end
    bry <= 1'b0;
    rry <= 1'b0;
  endtask
  task automatic tally_and_finish();
    $display("comparisons=%0d fail_count=%0d", comparisons, fail_count);
    if (fail_count == 0 && comparisons > 0) begin
      $display("== PASSED ==");
    end else begin
      $display("== FAILED ==");
    end
    $finish;
  endtask
  always @(posedge clk) begin
    cyc <= cyc + 1;
    if (cyc == 20000) begin
      fail_count++;
      tally_and_finish();
    end
  end

  // ****
  // Scenarios
  // ****
  initial begin
    repeat (12) @(posedge clk);
    rst <= 1'b0;
    bus(1'b0, SCS_OFF_CTRL, 32'h0);
    check(rdat, {24'h0, SCS_CTRL_RST});
    bus(1'b0, 5'h18, 32'h0);
    check({30'h0, resp}, {30'h0, SCS_RESP_SLVERR});
    bus(1'b1, 5'h1c, 32'hff);
    check({30'h0, resp}, {30'h0, SCS_RESP_SLVERR});
    // Every mode, card and guard case; settings change while running
    for (int n = 0; n < 32; n++) begin
      v = rnd();
      v[1:0] = {n[4] && !(n[0] && !n[1]), n[3]};
      bus(1'b1, SCS_OFF_MODE, {29'h0, n[1], 1'b0, n[2]});
      bus(1'b1, SCS_OFF_CARD, {31'h0, n[0]});
      ext_on <= !n[0] && n[4]; // Peer drives the pin clock
      bus(1'b1, SCS_OFF_CTRL, {24'h0, v[7:4], 2'h0, v[1:0]});
      @(negedge clk);
      check({oe_n, port, xext, x16}, pins(n[0], n[1], n[2], v[1:0]));
      check({txe, rxe}, v[5:4]);
      if (n[0] && n[1] && !v[0]) check(sck_o, v[1]);
    end
    // Fill the buffer in card mode with transmit off
    bus(1'b1, SCS_OFF_CTRL, 32'h80);
    for (int i = 0; i < SCS_FIFO_DEPTH; i++) begin
      v = rnd();
      exp_q.push_back(v[7:0]);
      bus(1'b1, SCS_OFF_TXD, v);
    end
    @(negedge clk);
    check({tirq, txv}, 2'h0);
    bus(1'b1, SCS_OFF_CTRL, 32'ha1);
    while (peer.log_q.size() < SCS_FIFO_DEPTH) begin
      @(posedge clk);
      v = rnd();
      stall <= v[0];
    end
    stall <= 1'b0;
    foreach (exp_q[i]) check(peer.log_q[i], exp_q[i]);
    @(negedge clk);
    check(tirq, 1'b1);
    bus(1'b1, SCS_OFF_CTRL, 32'h21);
    @(negedge clk);
    check(tirq, 1'b0);
    // Receive path, irq gating and errors
    bus(1'b1, SCS_OFF_CARD, 32'h0);
    bus(1'b1, SCS_OFF_MODE, 32'h0);
    bus(1'b1, SCS_OFF_CTRL, 32'h54);
    v = rnd();
    peer.send(v[7:0], 1'b0, 1'b0);
    @(negedge clk);
    check({rxe, rirq, eirq}, 3'h6);
    check(teirq, 1'b1);
    bus(1'b0, SCS_OFF_RXD, 32'h0);
    check(rdat, {24'h0, v[7:0]});
    check(rirq, 1'b0);
    peer.send(v[15:8], 1'b0, 1'b1);
    @(negedge clk);
    check(eirq, 1'b1);
    bus(1'b1, SCS_OFF_CTRL, 32'h10);
    @(negedge clk);
    check({rirq, eirq, teirq}, 3'h0);
    bus(1'b1, SCS_OFF_STAT, 32'h0c);
    bus(1'b0, SCS_OFF_RXD, 32'h0);
    bus(1'b1, SCS_OFF_CTRL, 32'h40);
    peer.send(8'h5a, 1'b0, 1'b0);
    bus(1'b0, SCS_OFF_STAT, 32'h0);
    check(rdat[1], 1'b0);
    // Address wake honoured only with the multiprocessor format
    for (int m = 1; m >= 0; m--) begin
      bus(1'b1, SCS_OFF_MODE, {30'h0, m[0], 1'b0});
      bus(1'b1, SCS_OFF_CTRL, 32'h58);
      peer.send(8'h33, 1'b0, 1'b0);
      bus(1'b0, SCS_OFF_STAT, 32'h0);
      check(rdat[1], !m[0]);
      peer.send(8'hc4, 1'b1, 1'b0);
      bus(1'b0, SCS_OFF_CTRL, 32'h0);
      check(rdat[3], !m[0]);
      bus(1'b0, SCS_OFF_RXD, 32'h0);
      check(rdat[7:0], 8'hc4);
      bus(1'b1, SCS_OFF_STAT, 32'h0c);
    end
    tally_and_finish();
  end
endmodule // serial_control_clock_select_tb
